// ### verilog/tsmh_stamp_regs.sv
`timescale 1ns/1ps
module tsmh_stamp_regs (
  // Clock, reset, enable
  input wire logic clk_in,
  input wire logic rst_n_in,
  input wire logic ce_in,
  // Live counters and format
  input wire tsmh_pkg::tsmh_time_s live_in,
  input wire logic hour_12_in,
  // Stamp control
  input wire logic stamp_enable_in,
  input wire logic stamp_overwrite_select_in,
  input wire logic stamp_clear_in,
  input wire logic event_in,
  // Host register port
  input wire logic [7:0] reg_addr_in,
  input wire logic reg_rd_in,
  input wire logic reg_wr_in,
  input wire logic [7:0] reg_wdata_in,
  output logic [7:0] reg_rdata_out,
  output logic reg_rvalid_out,
  // Stamp values
  output logic [7:0] minutes_stamp_out,
  output logic [7:0] hours_stamp_out
);

  // ==========================================================
  // Event qualification
  tsmh_pkg::tsmh_state_e state;
  tsmh_pkg::tsmh_state_e next_state;
  logic qualify;
  tsmh_pkg::tsmh_time_s stamp;

  // First-event mode captures only while armed
  assign qualify = event_in && stamp_enable_in &&
                   (stamp_overwrite_select_in || (state == tsmh_pkg::TSMH_ARMED));

  always_comb begin
    next_state = state;
    case (state)
      tsmh_pkg::TSMH_ARMED: begin
        if (qualify) begin
          next_state = tsmh_pkg::TSMH_HELD;
        end
      end
      tsmh_pkg::TSMH_HELD: begin
        // Qualifying overwrite-mode event in the clear cycle wins
        if (stamp_clear_in && !qualify) begin
          next_state = tsmh_pkg::TSMH_ARMED;
        end
      end
      default: begin
        next_state = tsmh_pkg::TSMH_ARMED;
      end
    endcase
  end

  always_ff @(posedge clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      state <= tsmh_pkg::TSMH_ARMED;
    end else if (ce_in) begin
      state <= next_state;
    end
  end

  // ==========================================================
  // Stamp storage
  tsmh_capture u_capture (
    .clk_in(clk_in),
    .rst_n_in(rst_n_in),
    .ce_in(ce_in),
    .capture_in(qualify),
    .clear_in(stamp_clear_in),
    .live_in(live_in),
    .stamp_out(stamp)
  );

  assign minutes_stamp_out = stamp.minutes;
  assign hours_stamp_out = stamp.hours;

  // ==========================================================
  // Read port; writes are ignored
  logic [7:0] rdata;
  logic [7:0] next_rdata;
  logic rvalid;
  logic next_rvalid;

  always_comb begin
    next_rdata = rdata;
    next_rvalid = reg_rd_in;
    if (reg_rd_in) begin
      case (reg_addr_in)
        tsmh_pkg::TSMH_MINUTES_OFS: next_rdata = stamp.minutes;
        tsmh_pkg::TSMH_HOURS_OFS: next_rdata = stamp.hours;
        default: next_rdata = tsmh_pkg::TSMH_UNMAPPED_VAL;
      endcase
    end
  end

  always_ff @(posedge clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      rdata <= tsmh_pkg::TSMH_RDATA_RST;
      rvalid <= 1'b0;
    end else if (ce_in) begin
      rdata <= next_rdata;
      rvalid <= next_rvalid;
    end
  end

  assign reg_rdata_out = rdata;
  assign reg_rvalid_out = rvalid;

  // ==========================================================
  // Checks
  default clocking cb @(posedge clk_in);
  endclocking
  default disable iff (!rst_n_in);

  sequence rd_minutes;
    ce_in && reg_rd_in && (reg_addr_in == tsmh_pkg::TSMH_MINUTES_OFS);
  endsequence

  sequence rd_hours;
    ce_in && reg_rd_in && (reg_addr_in == tsmh_pkg::TSMH_HOURS_OFS);
  endsequence

  sequence held_first;
    ce_in && (state == tsmh_pkg::TSMH_HELD) && !stamp_overwrite_select_in && !stamp_clear_in;
  endsequence

  sequence host_write_only;
    ce_in && reg_wr_in && !qualify && !stamp_clear_in;
  endsequence

  chk_minutes_bit7: assert property (minutes_stamp_out[7] == 1'b0)
    else $error("minutes stamp bit 7 set");

  chk_hours_top_zero: assert property (hours_stamp_out[7:6] == 2'b00)
    else $error("hours stamp bits 7:6 set");

  chk_write_ignored: assert property (host_write_only |=>
      $stable(minutes_stamp_out) && $stable(hours_stamp_out))
    else $error("host write changed a stamp");

  chk_clear_zeroes: assert property (ce_in && stamp_clear_in && !qualify |=>
      minutes_stamp_out == 8'h00 && hours_stamp_out == 8'h00)
    else $error("clear did not zero stamps");

  chk_capture_pair: assert property (ce_in && qualify |=>
      minutes_stamp_out == ($past(live_in.minutes) & tsmh_pkg::TSMH_MINUTES_MASK) &&
      hours_stamp_out == ($past(live_in.hours) & tsmh_pkg::TSMH_HOURS_MASK))
    else $error("stamps not captured together");

  chk_first_kept: assert property (held_first |=>
      $stable(minutes_stamp_out) && $stable(hours_stamp_out))
    else $error("first event stamp overwritten");

  chk_last_taken: assert property (ce_in && event_in && stamp_enable_in &&
      stamp_overwrite_select_in |=>
      minutes_stamp_out == ($past(live_in.minutes) & tsmh_pkg::TSMH_MINUTES_MASK) &&
      hours_stamp_out == ($past(live_in.hours) & tsmh_pkg::TSMH_HOURS_MASK))
    else $error("latest event not stamped");

  chk_meridian_copy: assert property (ce_in && qualify && hour_12_in |=>
      hours_stamp_out[tsmh_pkg::TSMH_MERIDIAN_BIT] ==
      $past(live_in.hours[tsmh_pkg::TSMH_MERIDIAN_BIT]))
    else $error("meridian flag not copied");

  chk_read_minutes: assert property (rd_minutes |=>
      reg_rvalid_out && reg_rdata_out == $past(minutes_stamp_out))
    else $error("minutes read mismatch");

  chk_read_hours: assert property (rd_hours |=>
      reg_rvalid_out && reg_rdata_out == $past(hours_stamp_out))
    else $error("hours read mismatch");

  chk_freeze_ce: assert property (!ce_in |=> $stable(state) && $stable(reg_rdata_out) &&
      $stable(minutes_stamp_out))
    else $error("state moved with clock enable low");

  // ==========================================================
  // Control and read port checks
  sequence evt_armed;
    ce_in && event_in && stamp_enable_in && (state == tsmh_pkg::TSMH_ARMED);
  endsequence

  sequence clear_only;
    ce_in && stamp_clear_in && !qualify;
  endsequence

  sequence evt_with_clear;
    ce_in && qualify && stamp_clear_in;
  endsequence

  sequence idle_disabled;
    ce_in && !stamp_enable_in && !stamp_clear_in;
  endsequence

  sequence no_read;
    ce_in && !reg_rd_in;
  endsequence

  sequence rd_other;
    ce_in && reg_rd_in && (reg_addr_in != tsmh_pkg::TSMH_MINUTES_OFS) &&
      (reg_addr_in != tsmh_pkg::TSMH_HOURS_OFS);
  endsequence

  chk_armed_takes: assert property (evt_armed |=> state == tsmh_pkg::TSMH_HELD)
    else $error("armed event did not hold");

  chk_clear_rearms: assert property (clear_only |=> state == tsmh_pkg::TSMH_ARMED)
    else $error("clear did not rearm capture");

  chk_event_beats_clear: assert property (evt_with_clear |=>
      minutes_stamp_out == ($past(live_in.minutes) & tsmh_pkg::TSMH_MINUTES_MASK) &&
      state == tsmh_pkg::TSMH_HELD)
    else $error("clear beat a same-cycle event");

  chk_disabled_hold: assert property (idle_disabled |=>
      $stable(minutes_stamp_out) && $stable(hours_stamp_out))
    else $error("stamp changed while disabled");

  chk_rvalid_pulse: assert property (no_read |=> !reg_rvalid_out)
    else $error("read valid without a read");

  chk_rdata_hold: assert property (no_read |=> $stable(reg_rdata_out))
    else $error("read data moved without a read");

  chk_read_unmapped: assert property (rd_other |=>
      reg_rdata_out == tsmh_pkg::TSMH_UNMAPPED_VAL)
    else $error("unmapped read not zero");

endmodule : tsmh_stamp_regs

// ### verilog/tsmh_pkg.sv
package tsmh_pkg;

  // ==========================================================
  // Register map
  localparam logic [7:0] TSMH_MINUTES_OFS = 8'h16;
  localparam logic [7:0] TSMH_HOURS_OFS = 8'h17;
  localparam logic [7:0] TSMH_MINUTES_RST = 8'h00;
  localparam logic [7:0] TSMH_HOURS_RST = 8'h00;
  localparam logic [7:0] TSMH_RDATA_RST = 8'h00;
  localparam logic [7:0] TSMH_UNMAPPED_VAL = 8'h00;

  // ==========================================================
  // Field layouts
  localparam logic [7:0] TSMH_MINUTES_MASK = 8'h7f;
  localparam logic [7:0] TSMH_HOURS_MASK = 8'h3f;
  localparam int TSMH_MERIDIAN_BIT = 5;

  // ==========================================================
  // Types
  typedef struct packed {
    logic [7:0] minutes;
    logic [7:0] hours;
  } tsmh_time_s;

  typedef enum logic [1:0] {
    TSMH_ARMED = 2'b01,
    TSMH_HELD = 2'b10
  } tsmh_state_e;

endpackage : tsmh_pkg

// ### verilog/tsmh_capture.sv
`timescale 1ns/1ps
module tsmh_capture (
  // Clock, reset and enable
  input wire logic clk_in,
  input wire logic rst_n_in,
  input wire logic ce_in,
  // Control
  input wire logic capture_in,
  input wire logic clear_in,
  input wire tsmh_pkg::tsmh_time_s live_in,
  // Stamps
  output tsmh_pkg::tsmh_time_s stamp_out
);

  // ==========================================================
  // Stamp registers
  tsmh_pkg::tsmh_time_s stamp;
  tsmh_pkg::tsmh_time_s next_stamp;

  always_comb begin
    next_stamp = stamp;
    if (capture_in) begin
      // Both fields in one cycle, masked to their defined bits
      next_stamp.minutes = live_in.minutes & tsmh_pkg::TSMH_MINUTES_MASK;
      next_stamp.hours = live_in.hours & tsmh_pkg::TSMH_HOURS_MASK;
    end else if (clear_in) begin
      next_stamp.minutes = tsmh_pkg::TSMH_MINUTES_RST;
      next_stamp.hours = tsmh_pkg::TSMH_HOURS_RST;
    end
  end

  always_ff @(posedge clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      stamp.minutes <= tsmh_pkg::TSMH_MINUTES_RST;
      stamp.hours <= tsmh_pkg::TSMH_HOURS_RST;
    end else if (ce_in) begin
      stamp <= next_stamp;
    end
  end

  assign stamp_out = stamp;

endmodule : tsmh_capture

// ### bench/tb_top.sv
`timescale 1ns/1ps
module tb_top;
  // ==========================================
  // Signals
  logic clk_in = 1'b0;
  logic rst_n_in = 1'b0;
  tsmh_pkg::tsmh_time_s live = '0;
  logic hour_12 = 1'b0, en = 1'b0, ow = 1'b0, clr = 1'b0, evt = 1'b0, rd = 1'b0, wr = 1'b0;
  logic ce = 1'b1;
  logic [7:0] addr = 8'h00, wdata = 8'h00;
  logic [7:0] rdata, min_st, hr_st;
  logic rvalid;
  int failures = 0;
  int num_checks = 0;
  always #5 clk_in = ~clk_in;
  tsmh_stamp_regs u_dut (.clk_in(clk_in), .rst_n_in(rst_n_in), .ce_in(ce),
    .live_in(live), .hour_12_in(hour_12), .stamp_enable_in(en),
    .stamp_overwrite_select_in(ow), .stamp_clear_in(clr), .event_in(evt),
    .reg_addr_in(addr), .reg_rd_in(rd), .reg_wr_in(wr), .reg_wdata_in(wdata),
    .reg_rdata_out(rdata), .reg_rvalid_out(rvalid),
    .minutes_stamp_out(min_st), .hours_stamp_out(hr_st));
  // ==========================================
  // Shared tasks
  task check(input logic [7:0] seen, input logic [7:0] exp);
    num_checks++;
    if (seen !== exp) begin
      failures++;
      $display("[ERR] %0t seen %h expected %h", $time, seen, exp);
    end
  endtask : check
  task rd_chk(input logic [7:0] a, input logic [7:0] exp);
    @(negedge clk_in);
    addr = a;
    rd = 1'b1;
    @(negedge clk_in);
    rd = 1'b0;
    check({7'h00, rvalid}, 8'h01);
    check(rdata, exp);
    @(negedge clk_in);
    check({7'h00, rvalid}, 8'h00);
  endtask : rd_chk
  task fire(input logic [15:0] v, input logic e, input logic c);
    @(negedge clk_in);
    live = v;
    evt = e;
    clr = c;
    @(negedge clk_in);
    evt = 1'b0;
    clr = 1'b0;
  endtask : fire
  task stamps(input logic [7:0] m, input logic [7:0] h);
    check(min_st, m);
    check(hr_st, h);
  endtask : stamps
  // ==========================================
  // Scenarios
  task t_reset;
    rd_chk(8'h16, 8'h00);
    rd_chk(8'h17, 8'h00);
    rd_chk(8'h15, 8'h00);
  endtask : t_reset
  task t_first;
    en = 1'b1;
    fire({8'hd9, 8'he3}, 1'b1, 1'b0);
    stamps(8'h59, 8'h23);
    fire({8'h10, 8'h05}, 1'b1, 1'b0);
    stamps(8'h59, 8'h23);
    rd_chk(8'h16, 8'h59);
  endtask : t_first
  task t_write;
    @(negedge clk_in);
    addr = 8'h16;
    wdata = 8'h3c;
    wr = 1'b1;
    @(negedge clk_in);
    addr = 8'h17;
    @(negedge clk_in);
    wr = 1'b0;
    rd_chk(8'h16, 8'h59);
    rd_chk(8'h17, 8'h23);
  endtask : t_write
  task t_clear;
    fire({8'h44, 8'h11}, 1'b0, 1'b1);
    stamps(8'h00, 8'h00);
    fire({8'h45, 8'h07}, 1'b1, 1'b0);
    stamps(8'h45, 8'h07);
  endtask : t_clear
  task t_latest;
    ow = 1'b1;
    hour_12 = 1'b1;
    fire({8'h30, 8'h31}, 1'b1, 1'b0);
    stamps(8'h30, 8'h31);
    fire({8'h01, 8'h12}, 1'b1, 1'b0);
    stamps(8'h01, 8'h12);
    rd_chk(8'h17, 8'h12);
    en = 1'b0;
    fire({8'h02, 8'h29}, 1'b1, 1'b0);
    stamps(8'h01, 8'h12);
  endtask : t_latest
  task t_midreset;
    @(negedge clk_in);
    rst_n_in = 1'b0;
    @(negedge clk_in);
    stamps(8'h00, 8'h00);
    check(rdata, 8'h00);
    check({7'h00, rvalid}, 8'h00);
    rst_n_in = 1'b1;
    en = 1'b1;
    ow = 1'b0;
    fire({8'h12, 8'h34}, 1'b1, 1'b0);
    stamps(8'h12, 8'h34);
    fire({8'h13, 8'h35}, 1'b1, 1'b0);
    stamps(8'h12, 8'h34);
  endtask : t_midreset
  task t_freeze;
    ow = 1'b1;
    @(negedge clk_in);
    ce = 1'b0;
    live = {8'h22, 8'h08};
    evt = 1'b1;
    addr = 8'h17;
    rd = 1'b1;
    @(negedge clk_in);
    ce = 1'b1;
    evt = 1'b0;
    rd = 1'b0;
    stamps(8'h12, 8'h34);
    check({7'h00, rvalid}, 8'h00);
    check(rdata, 8'h00);
  endtask : t_freeze
  task t_both;
    fire({8'h47, 8'h52}, 1'b1, 1'b1);
    stamps(8'h47, 8'h12);
    ow = 1'b0;
    fire({8'h48, 8'h13}, 1'b1, 1'b0);
    stamps(8'h47, 8'h12);
  endtask : t_both
  // ==========================================
  // Verdict
  task print_verdict;
    $display("checks %0d failures %0d", num_checks, failures);
    if (failures == 0 && num_checks > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask : print_verdict
  initial begin
    repeat (4) @(posedge clk_in);
    @(negedge clk_in);
    rst_n_in = 1'b1;
    t_reset();
    t_first();
    t_write();
    t_clear();
    t_latest();
    t_midreset();
    t_freeze();
    t_both();
    print_verdict();
  end
  initial begin
    #20000;
    failures++;
    print_verdict();
  end
endmodule : tb_top
